//--- rtl/e1ccr_consts.svh
// register indices, field positions, reset values and counts of e1ccr
`ifndef E1CCR_CONSTS_SVH
`define E1CCR_CONSTS_SVH

// register indices; byte address is four times the index
`define E1CCR_IDX_CTRL3 8'h1B
`define E1CCR_IDX_CTRL4 8'h1C
`define E1CCR_IDX_ISTAT 8'h1D
`define E1CCR_IDX_ICLR 8'h1E
`define E1CCR_IDX_IEN 8'h1F
`define E1CCR_IDX_TXMON 8'h20

// common_control_three fields
`define E1CCR_TX_ESTORE_ENABLE 7
`define E1CCR_TX_BLOCK_FUNC_SELECT 6
`define E1CCR_TX_IDLE_FUNC_SELECT 5
`define E1CCR_ESTORES_RESET 4
`define E1CCR_RX_SIG_REINSERT_ENABLE 3
`define E1CCR_TX_HW_SIG_INSERT_ENABLE 2
`define E1CCR_TX_BACKPLANE_CLK_SELECT 1
`define E1CCR_CARRIER_LOSS_ALT_CRITERIA 0

// common_control_four fields
`define E1CCR_REMOTE_LOOP_ENABLE 7
`define E1CCR_LOCAL_LOOP_ENABLE 6
`define E1CCR_TX_CHAN_MONITOR_SEL_MSB 4
`define E1CCR_TX_CHAN_MONITOR_SEL_LSB 0

// interrupt status bits
`define E1CCR_EV_LOSS_SET 0
`define E1CCR_EV_LOSS_CLEAR 1
`define E1CCR_EV_RECENTER 2
`define E1CCR_EV_MONITOR 3

// reset values
`define E1CCR_RST_CTRL3 8'h00
`define E1CCR_RST_CTRL4 8'h00
`define E1CCR_RST_IEN 4'h0

// consecutive zero counts for carrier loss
`define E1CCR_LOSS_ZEROS 12'h0FF
`define E1CCR_LOSS_ZEROS_ALT 12'h800

// axi responses
`define E1CCR_RESP_OKAY 2'h0
`define E1CCR_RESP_SLVERR 2'h2

`endif

//--- rtl/e1ccr_pkg.sv
// types of the e1 common control register bank
`default_nettype none
package e1ccr_pkg;

    // whole state of the block, registered in one place
    typedef struct packed {
        logic [7:0] ctrl3;
        logic [7:0] ctrl4;
        logic [3:0] istat;
        logic [3:0] ien;
        logic [7:0] txmon;
        logic aw_held;
        logic [7:0] aw_idx;
        logic w_held;
        logic [7:0] wdata;
        logic wstb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [2:0] pos_sync;
        logic [2:0] neg_sync;
        logic pos_f;
        logic neg_f;
        logic [11:0] zero_cnt;
        logic carrier_loss;
        logic reset_bit_prev;
        logic recenter;
        logic tx_pos;
        logic tx_neg;
        logic line_pos;
        logic line_neg;
        logic chan_block;
        logic idle_ins;
        logic loop_ins;
        logic sig_chan;
        logic tx_ser;
        logic irq;
    } e1ccr_state_t;

endpackage
`default_nettype wire

//--- rtl/e1ccr_regs.sv
// e1 common control registers with axi4-lite slave and simple datapath
//
// Operation
// RULE1: estore enable bit puts estore in path
// RULE2: block select: block output or signaling insert
// RULE3: idle select: idle code or per-channel loopback
// RULE4: reset bit falling recenters both elastic stores
// RULE5: host pulses estore reset, never left set
// RULE6: reinsert enable drives receive signaling reinsertion
// RULE7: hw insert takes signaling pin into transmit
// RULE8: host sets clock select per backplane rate
// RULE9: carrier loss after 255 or 2048 zeros
// RULE10: 5-bit select picks monitored transmit channel
// RULE11: remote loop returns receive rails to transmit
// RULE12: local loop feeds transmit data to receiver
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "e1ccr_consts.svh"

module e1ccr_regs #(
    parameter int ADDR_W = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_pos_rail_in,
    input wire logic rx_neg_rail_in,
    input wire logic fmt_pos_in,
    input wire logic fmt_neg_in,
    input wire logic rx_bit_stb,
    input wire logic tx_block_bit,
    input wire logic tx_idle_bit,
    input wire logic tx_serial_in,
    input wire logic tx_signaling_in,
    input wire logic tx_sig_slot,
    input wire logic tx_chan_stb,
    input wire logic [4:0] tx_chan_idx,
    input wire logic [7:0] tx_chan_data,
    output logic tx_pos_rail_out,
    output logic tx_neg_rail_out,
    output logic line_pos_out,
    output logic line_neg_out,
    output logic tx_estore_enable,
    output logic estores_reset,
    output logic estore_recenter,
    output logic rx_sig_reinsert_enable,
    output logic tx_backplane_clk_select,
    output logic tx_chan_block_out,
    output logic tx_sig_insert_chan,
    output logic tx_idle_code_insert,
    output logic tx_idle_loop_insert,
    output logic tx_serial_out,
    output logic carrier_loss,
    output logic [7:0] tx_monitor_data_reg,
    output logic irq
);

    // the register index sits in address bits [9:2]; a narrower bus
    // cannot reach every register, so elaboration stops here rather
    // than leaving a silently truncated decode
    if (ADDR_W < 10) begin : g_addr_check
        $error("e1ccr_regs: ADDR_W must be at least 10");
    end

    e1ccr_pkg::e1ccr_state_t s_reg;
    e1ccr_pkg::e1ccr_state_t s_next;

    logic [7:0] aw_idx;
    logic [7:0] ar_idx;
    logic do_write;
    logic lp;
    logic ln;
    logic [11:0] loss_limit;
    logic [3:0] ev;
    logic [3:0] clr;

    assign aw_idx = s_axi_awaddr[9:2];
    assign ar_idx = s_axi_araddr[9:2];

    // ------------------------------------------------------------
    // bus handshakes
    // ------------------------------------------------------------
    // one write at a time: address and data are held until answered
    assign s_axi_awready = !s_reg.aw_held && !s_reg.bvalid;
    assign s_axi_wready = !s_reg.w_held && !s_reg.bvalid;
    assign s_axi_arready = !s_reg.rvalid;
    assign do_write = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;

    // line data toward the receive framer and jitter attenuator
    // RULE12: local loop substitution
    assign lp = s_reg.ctrl4[`E1CCR_LOCAL_LOOP_ENABLE] ? fmt_pos_in
                                                      : s_reg.pos_f;
    assign ln = s_reg.ctrl4[`E1CCR_LOCAL_LOOP_ENABLE] ? fmt_neg_in
                                                      : s_reg.neg_f;

    // RULE9: zero count limit
    assign loss_limit = s_reg.ctrl3[`E1CCR_CARRIER_LOSS_ALT_CRITERIA]
                        ? `E1CCR_LOSS_ZEROS_ALT : `E1CCR_LOSS_ZEROS;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        ev = 4'h0;
        clr = 4'h0;

        // capture write address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_next.aw_held = 1'b1;
            s_next.aw_idx = aw_idx;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_next.w_held = 1'b1;
            s_next.wdata = s_axi_wdata[7:0];
            s_next.wstb = s_axi_wstrb[0];
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end

        // register write; only byte lane 0 carries data
        if (do_write) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = `E1CCR_RESP_OKAY;
            if (s_reg.aw_idx == `E1CCR_IDX_CTRL3) begin
                if (s_reg.wstb) begin
                    s_next.ctrl3 = s_reg.wdata;
                end
            end else if (s_reg.aw_idx == `E1CCR_IDX_CTRL4) begin
                if (s_reg.wstb) begin
                    s_next.ctrl4 = s_reg.wdata;
                end
            end else if (s_reg.aw_idx == `E1CCR_IDX_ICLR) begin
                if (s_reg.wstb) begin
                    clr = s_reg.wdata[3:0];
                end
            end else if (s_reg.aw_idx == `E1CCR_IDX_IEN) begin
                if (s_reg.wstb) begin
                    s_next.ien = s_reg.wdata[3:0];
                end
            end else if (s_reg.aw_idx == `E1CCR_IDX_ISTAT ||
                         s_reg.aw_idx == `E1CCR_IDX_TXMON) begin
                s_next.bresp = `E1CCR_RESP_OKAY; // read-only, ignored
            end else begin
                s_next.bresp = `E1CCR_RESP_SLVERR;
            end
        end

        // read answer one cycle after the address is taken
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = 32'h0000_0000;
            s_next.rresp = `E1CCR_RESP_OKAY;
            if (ar_idx == `E1CCR_IDX_CTRL3) begin
                s_next.rdata[7:0] = s_reg.ctrl3;
            end else if (ar_idx == `E1CCR_IDX_CTRL4) begin
                s_next.rdata[7:0] = s_reg.ctrl4;
            end else if (ar_idx == `E1CCR_IDX_ISTAT) begin
                s_next.rdata[3:0] = s_reg.istat;
            end else if (ar_idx == `E1CCR_IDX_ICLR) begin
                s_next.rdata[3:0] = 4'h0; // write-only
            end else if (ar_idx == `E1CCR_IDX_IEN) begin
                s_next.rdata[3:0] = s_reg.ien;
            end else if (ar_idx == `E1CCR_IDX_TXMON) begin
                s_next.rdata[7:0] = s_reg.txmon;
            end else begin
                s_next.rresp = `E1CCR_RESP_SLVERR;
            end
        end

        // pin synchronisers; a change counts once stages 2 and 3 agree
        s_next.pos_sync = {s_reg.pos_sync[1:0], rx_pos_rail_in};
        s_next.neg_sync = {s_reg.neg_sync[1:0], rx_neg_rail_in};
        if (s_reg.pos_sync[1] == s_reg.pos_sync[2]) begin
            s_next.pos_f = s_reg.pos_sync[2];
        end
        if (s_reg.neg_sync[1] == s_reg.neg_sync[2]) begin
            s_next.neg_f = s_reg.neg_sync[2];
        end

        // RULE11: remote loop rail selection
        s_next.tx_pos = s_reg.ctrl4[`E1CCR_REMOTE_LOOP_ENABLE]
                        ? s_reg.pos_f : fmt_pos_in;
        s_next.tx_neg = s_reg.ctrl4[`E1CCR_REMOTE_LOOP_ENABLE]
                        ? s_reg.neg_f : fmt_neg_in;
        // framer side keeps receiving in remote loop
        s_next.line_pos = lp;
        s_next.line_neg = ln;

        // RULE9: consecutive zero counter, saturating
        if (rx_bit_stb) begin
            if (lp || ln) begin
                s_next.zero_cnt = 12'h000;
                s_next.carrier_loss = 1'b0;
                ev[`E1CCR_EV_LOSS_CLEAR] = s_reg.carrier_loss;
            end else begin
                if (s_reg.zero_cnt != `E1CCR_LOSS_ZEROS_ALT) begin
                    s_next.zero_cnt = s_reg.zero_cnt + 12'h001;
                end
                if (s_next.zero_cnt >= loss_limit) begin
                    s_next.carrier_loss = 1'b1;
                    ev[`E1CCR_EV_LOSS_SET] = !s_reg.carrier_loss;
                end
            end
        end

        // RULE4: recenter on the falling edge of the reset bit
        s_next.reset_bit_prev = s_reg.ctrl3[`E1CCR_ESTORES_RESET];
        s_next.recenter = s_reg.reset_bit_prev &&
                          !s_reg.ctrl3[`E1CCR_ESTORES_RESET];
        ev[`E1CCR_EV_RECENTER] = s_reg.recenter;

        // RULE2: blocking registers steer block pin or insertion
        s_next.chan_block = tx_block_bit &&
                    !s_reg.ctrl3[`E1CCR_TX_BLOCK_FUNC_SELECT];
        s_next.sig_chan = tx_block_bit &&
                    s_reg.ctrl3[`E1CCR_TX_BLOCK_FUNC_SELECT];
        // RULE3: idle registers pick idle code or loopback
        s_next.idle_ins = tx_idle_bit &&
                    !s_reg.ctrl3[`E1CCR_TX_IDLE_FUNC_SELECT];
        s_next.loop_ins = tx_idle_bit &&
                    s_reg.ctrl3[`E1CCR_TX_IDLE_FUNC_SELECT];
        // RULE7: signaling pin replaces serial data in its slot
        s_next.tx_ser = (tx_sig_slot &&
                    s_reg.ctrl3[`E1CCR_TX_HW_SIG_INSERT_ENABLE])
                        ? tx_signaling_in : tx_serial_in;

        // RULE10: copy the selected channel into the monitor
        if (tx_chan_stb && tx_chan_idx == s_reg.ctrl4[4:0]) begin
            s_next.txmon = tx_chan_data;
            ev[`E1CCR_EV_MONITOR] = 1'b1;
        end

        // sticky status: a new event wins over a clear
        s_next.istat = (s_reg.istat & ~clr) | ev;
        s_next.irq = |(s_next.istat & s_next.ien);
    end

    // ------------------------------------------------------------
    // state register, synchronous reset
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.ctrl3 <= `E1CCR_RST_CTRL3;
            s_reg.ctrl4 <= `E1CCR_RST_CTRL4;
            s_reg.ien <= `E1CCR_RST_IEN;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs, all from flip-flops
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign s_axi_rvalid = s_reg.rvalid;
    assign tx_pos_rail_out = s_reg.tx_pos;
    assign tx_neg_rail_out = s_reg.tx_neg;
    assign line_pos_out = s_reg.line_pos;
    assign line_neg_out = s_reg.line_neg;
    // RULE1: estore in path when enabled, bypassed otherwise
    assign tx_estore_enable = s_reg.ctrl3[`E1CCR_TX_ESTORE_ENABLE];
    // level held: stores stay in reset while the bit is high
    assign estores_reset = s_reg.ctrl3[`E1CCR_ESTORES_RESET];
    assign estore_recenter = s_reg.recenter;
    // RULE6: reinsertion follows its enable bit
    assign rx_sig_reinsert_enable =
        s_reg.ctrl3[`E1CCR_RX_SIG_REINSERT_ENABLE];
    assign tx_backplane_clk_select =
        s_reg.ctrl3[`E1CCR_TX_BACKPLANE_CLK_SELECT];
    assign tx_chan_block_out = s_reg.chan_block;
    assign tx_sig_insert_chan = s_reg.sig_chan;
    assign tx_idle_code_insert = s_reg.idle_ins;
    assign tx_idle_loop_insert = s_reg.loop_ins;
    assign tx_serial_out = s_reg.tx_ser;
    assign carrier_loss = s_reg.carrier_loss;
    assign tx_monitor_data_reg = s_reg.txmon;
    assign irq = s_reg.irq;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_estore_write: assert property ( // RULE1
        @(posedge aclk) disable iff (!aresetn)
        (do_write && s_reg.wstb && s_reg.aw_idx == `E1CCR_IDX_CTRL3)
        |=> tx_estore_enable == $past(s_reg.wdata[7]))
        else $error("estore enable does not follow write");

    a_block_gate: assert property ( // RULE2
        @(posedge aclk) disable iff (!aresetn)
        tx_block_bit ##1 1'b1 |-> (tx_chan_block_out ==
            !$past(s_reg.ctrl3[6])) && (tx_sig_insert_chan ==
            $past(s_reg.ctrl3[6])))
        else $error("blocking bit routed wrongly");

    a_idle_select: assert property ( // RULE3
        @(posedge aclk) disable iff (!aresetn)
        tx_idle_loop_insert |-> $past(tx_idle_bit) &&
            $past(s_reg.ctrl3[5]) && !tx_idle_code_insert)
        else $error("idle loopback without select");

    a_recenter_fall: assert property ( // RULE4
        @(posedge aclk) disable iff (!aresetn)
        $fell(s_reg.ctrl3[4]) |=> estore_recenter ##1 !estore_recenter)
        else $error("no single recenter pulse on reset fall");

    a_reinsert_write: assert property ( // RULE6
        @(posedge aclk) disable iff (!aresetn)
        (do_write && s_reg.wstb && s_reg.aw_idx == `E1CCR_IDX_CTRL3)
        |=> rx_sig_reinsert_enable == $past(s_reg.wdata[3]))
        else $error("reinsert enable does not follow write");

    a_hw_sig_ins: assert property ( // RULE7
        @(posedge aclk) disable iff (!aresetn)
        (tx_sig_slot && s_reg.ctrl3[2]) |=>
            tx_serial_out == $past(tx_signaling_in))
        else $error("signaling pin not inserted");

    a_loss_count: assert property ( // RULE9
        @(posedge aclk) disable iff (!aresetn)
        $rose(carrier_loss) |-> s_reg.zero_cnt >= 12'h0FF &&
            (!$past(s_reg.ctrl3[0]) || s_reg.zero_cnt == 12'h800))
        else $error("carrier loss before zero count reached");

    a_loss_clear: assert property ( // RULE9
        @(posedge aclk) disable iff (!aresetn)
        (rx_bit_stb && (lp || ln)) |=> !carrier_loss &&
            s_reg.zero_cnt == 12'h000)
        else $error("carrier loss not cleared by a mark");

    a_monitor_copy: assert property ( // RULE10
        @(posedge aclk) disable iff (!aresetn)
        (tx_chan_stb && tx_chan_idx == s_reg.ctrl4[4:0]) |=>
            tx_monitor_data_reg == $past(tx_chan_data))
        else $error("monitored channel not copied");

    a_remote_loop: assert property ( // RULE11
        @(posedge aclk) disable iff (!aresetn)
        s_reg.ctrl4[7] |=> tx_pos_rail_out == $past(s_reg.pos_f) &&
            tx_neg_rail_out == $past(s_reg.neg_f))
        else $error("remote loop rails not returned");

    a_local_loop: assert property ( // RULE12
        @(posedge aclk) disable iff (!aresetn)
        s_reg.ctrl4[6] |=> line_pos_out == $past(fmt_pos_in) &&
            line_neg_out == $past(fmt_neg_in))
        else $error("local loop data not substituted");

endmodule // e1ccr_regs
`default_nettype wire

//--- dv/e1ccr_host.sv
// host processor model: axi4-lite master for the common control registers
`timescale 1ns/1ps
`default_nettype none
`include "e1ccr_consts.svh"

module e1ccr_host #(
    parameter int ADDR_W = 10
) (
    input wire logic aclk,
    output var logic [ADDR_W-1:0] s_axi_awaddr,
    output var logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output var logic [31:0] s_axi_wdata,
    output var logic [3:0] s_axi_wstrb,
    output var logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output var logic s_axi_bready,
    output var logic [ADDR_W-1:0] s_axi_araddr,
    output var logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output var logic s_axi_rready
);
    // bus idle from time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
    end

    // each channel drops at its own handshake; response closes the write
    task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= ADDR_W'({idx, 2'b00});
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    // read data is taken at the same edge as rvalid
    task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= ADDR_W'({idx, 2'b00});
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic estores_reset_pulse(input logic [7:0] base);
        logic [1:0] r;
        wr(`E1CCR_IDX_CTRL3, {24'h0, base | 8'h10}, r);
        wr(`E1CCR_IDX_CTRL3, {24'h0, base & 8'hEF}, r);
    endtask
endmodule // e1ccr_host
`default_nettype wire

//--- dv/e1ccr_regs_tb.sv
// self-checking bench for the e1 common control register bank
`timescale 1ns/1ps
`default_nettype none
`include "e1ccr_consts.svh"

module e1ccr_regs_tb;
    typedef struct packed {
        logic [7:0] idx;
        logic [31:0] wd;
        logic [1:0] wr;
        logic [31:0] rd;
        logic [1:0] rr;
    } e1ccr_row_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic rx_pos_rail_in, rx_neg_rail_in, fmt_pos_in, fmt_neg_in, rx_bit_stb;
    logic tx_block_bit, tx_idle_bit, tx_serial_in, tx_signaling_in;
    logic tx_sig_slot, tx_chan_stb, tx_pos_rail_out, tx_neg_rail_out;
    logic [4:0] tx_chan_idx;
    logic [7:0] tx_chan_data, tx_monitor_data_reg, v;
    logic line_pos_out, line_neg_out, tx_estore_enable, estores_reset;
    logic estore_recenter, rx_sig_reinsert_enable, tx_backplane_clk_select;
    logic tx_chan_block_out, tx_sig_insert_chan, tx_idle_code_insert;
    logic tx_idle_loop_insert, tx_serial_out, carrier_loss, irq;
    int num_errors = 0;
    int checks = 0;
    int rc_cnt = 0;
    // ordinary accesses: write, response, read back, response
    e1ccr_row_t rows [6] = '{
        '{8'h1B, 32'hFFFF_FFE7, 2'h0, 32'hE7, 2'h0},
        '{8'h1C, 32'h0000_00BF, 2'h0, 32'hBF, 2'h0},
        '{8'h1F, 32'h0000_00FF, 2'h0, 32'h0F, 2'h0},
        '{8'h20, 32'h0000_00AB, 2'h0, 32'h00, 2'h0},
        '{8'h21, 32'h0000_0001, 2'h2, 32'h00, 2'h2},
        '{8'h1A, 32'h0000_0001, 2'h2, 32'h00, 2'h2}};

    e1ccr_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_pos_rail_in,
        .rx_neg_rail_in, .fmt_pos_in, .fmt_neg_in, .rx_bit_stb,
        .tx_block_bit, .tx_idle_bit, .tx_serial_in, .tx_signaling_in,
        .tx_sig_slot, .tx_chan_stb, .tx_chan_idx, .tx_chan_data,
        .tx_pos_rail_out, .tx_neg_rail_out, .line_pos_out, .line_neg_out,
        .tx_estore_enable, .estores_reset, .estore_recenter,
        .rx_sig_reinsert_enable, .tx_backplane_clk_select,
        .tx_chan_block_out, .tx_sig_insert_chan, .tx_idle_code_insert,
        .tx_idle_loop_insert, .tx_serial_out, .carrier_loss,
        .tx_monitor_data_reg, .irq);
    e1ccr_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    initial aclk = 1'b0;
    always #5 aclk = ~aclk;
    // counts recenter pulses so a pulse on the rising write also shows
    always @(posedge aclk) if (estore_recenter === 1'b1) rc_cnt++;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic strobes(input int n);
        repeat (n) begin
            @(posedge aclk) rx_bit_stb <= 1'b1;
            @(posedge aclk) rx_bit_stb <= 1'b0;
        end
        // let the last strobe's result settle before anyone looks
        @(posedge aclk);
    endtask
    task automatic final_report;
        $display("num_errors=%0d checks=%0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watchdog: the run needs well under 20000 cycles
    initial begin
        #300us;
        num_errors++;
        final_report();
    end

    initial begin
        {aresetn, rx_pos_rail_in, rx_neg_rail_in, fmt_pos_in} = '0;
        {fmt_neg_in, rx_bit_stb, tx_block_bit, tx_idle_bit} = '0;
        {tx_serial_in, tx_signaling_in, tx_sig_slot, tx_chan_stb} = '0;
        {tx_chan_idx, tx_chan_data} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            host.rd(rows[i].idx, d, r);
            chk(d, 32'h0);
            host.wr(rows[i].idx, rows[i].wd, r);
            chk(r, rows[i].wr);
            host.rd(rows[i].idx, d, r);
            chk(d, rows[i].rd);
            chk(r, rows[i].rr);
        end
        // control levels; signaling slot picks the pin only when enabled
        {tx_block_bit, tx_idle_bit, tx_signaling_in, tx_sig_slot} <= 4'hF;
        for (int i = 0; i < 2; i++) begin
            v = i ? 8'h21 : 8'hCE;
            host.wr(`E1CCR_IDX_CTRL3, {24'h0, v}, r);
            repeat (2) @(posedge aclk);
            chk1(tx_estore_enable, v[7]);
            chk1(tx_chan_block_out, !v[6]);
            chk1(tx_sig_insert_chan, v[6]);
            chk1(tx_idle_code_insert, !v[5]);
            chk1(tx_idle_loop_insert, v[5]);
            chk1(rx_sig_reinsert_enable, v[3]);
            chk1(tx_serial_out, v[2]);
            chk1(tx_backplane_clk_select, v[1]);
        end
        // recenter once per pulse, raised then masked
        host.wr(`E1CCR_IDX_IEN, 32'h4, r);
        for (int i = 0; i < 2; i++) begin
            rc_cnt = 0;
            host.estores_reset_pulse(8'h00);
            repeat (4) @(posedge aclk);
            chk(rc_cnt, 1);
            chk1(estores_reset, 1'b0);
            chk1(irq, !i);
            host.rd(`E1CCR_IDX_ISTAT, d, r);
            chk(d, 32'h4);
            host.wr(`E1CCR_IDX_ICLR, 32'h4, r);
            repeat (2) @(posedge aclk);
            chk1(irq, 1'b0);
            host.wr(`E1CCR_IDX_IEN, 32'h0, r);
        end
        // loops: remote returns receive rails, local feeds formatter back
        {rx_pos_rail_in, rx_neg_rail_in, fmt_pos_in, fmt_neg_in} <= 4'h9;
        host.wr(`E1CCR_IDX_CTRL4, 32'h80, r);
        repeat (6) @(posedge aclk);
        chk({tx_pos_rail_out, tx_neg_rail_out}, 2'h2);
        chk1(line_pos_out, 1'b1);
        host.wr(`E1CCR_IDX_CTRL4, 32'h40, r);
        repeat (3) @(posedge aclk);
        chk({tx_pos_rail_out, tx_neg_rail_out}, 2'h1);
        chk({line_pos_out, line_neg_out}, 2'h1);
        {rx_pos_rail_in, fmt_neg_in} <= 2'h0;
        host.wr(`E1CCR_IDX_CTRL4, 32'h00, r);
        repeat (6) @(posedge aclk);
        // carrier loss exactly at the count; a mark ends it
        for (int a = 0; a < 2; a++) begin
            host.wr(`E1CCR_IDX_CTRL3, a, r);
            strobes(a ? 2047 : 254);
            chk1(carrier_loss, 1'b0);
            strobes(1);
            chk1(carrier_loss, 1'b1);
            rx_pos_rail_in <= 1'b1;
            repeat (6) @(posedge aclk);
            strobes(1);
            chk1(carrier_loss, 1'b0);
            rx_pos_rail_in <= 1'b0;
            repeat (6) @(posedge aclk);
        end
        // monitor channel 19 among its neighbours, msb of select used
        host.wr(`E1CCR_IDX_CTRL4, 32'h13, r);
        for (int j = 18; j < 21; j++) begin
            @(posedge aclk);
            tx_chan_stb <= 1'b1;
            tx_chan_idx <= 5'(j);
            tx_chan_data <= 8'(8'h40 + j);
        end
        @(posedge aclk) tx_chan_stb <= 1'b0;
        repeat (2) @(posedge aclk);
        chk(tx_monitor_data_reg, 8'h53);
        host.rd(`E1CCR_IDX_TXMON, d, r);
        chk(d, 32'h53);
        // loss declared, loss ended and monitor capture all latched
        host.rd(`E1CCR_IDX_ISTAT, d, r);
        chk(d, 32'hB);
        // second reset in mid-run clears registers and outputs
        @(posedge aclk) aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk(tx_monitor_data_reg, 8'h00);
        host.rd(`E1CCR_IDX_CTRL4, d, r);
        chk(d, 32'h0);
        final_report();
    end
endmodule // e1ccr_regs_tb
`default_nettype wire
